// *** hdl/gfiop_pkg.sv ***
package gfiop_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PIN2_FUNC_CFG = 8'h0d;
  localparam logic [7:0] ADDR_IO_PORT_CFG   = 8'h0e;
  localparam logic [7:0] ADDR_IRQ_STATUS    = 8'h20;
  localparam logic [7:0] ADDR_IRQ_MASK      = 8'h21;

  localparam logic [7:0] RST_PIN2_FUNC_CFG  = 8'h00;
  localparam logic [3:0] RST_IO_PORT_WR     = 4'h0;
  localparam logic [2:0] RST_IRQ_MASK       = 3'h0;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SEL_LSB      = 0;
  localparam int SEL_MSB      = 4;
  localparam int PULLUP_BIT   = 5;
  localparam int DRV_LSB      = 6;
  localparam int DRV_MSB      = 7;
  localparam int PORT_IRQ_SDO = 3;
  localparam int PORT_DIRECT_VALUE_PIN2    = 2;
  localparam int PORT_DIRECT_VALUE_PIN1    = 1;
  localparam int PORT_DIRECT_VALUE_PIN0    = 0;

  // ----------------------------------------------------------------
  // Function selector codes
  // ----------------------------------------------------------------
  localparam logic [4:0] SEL_MCU_CLK    = 5'h00;
  localparam logic [4:0] SEL_WAKEUP     = 5'h01;
  localparam logic [4:0] SEL_LOW_BATT   = 5'h02;
  localparam logic [4:0] SEL_DIRECT_IN  = 5'h03;
  localparam logic [4:0] SEL_EXTI_FALL  = 5'h04;
  localparam logic [4:0] SEL_EXTI_RISE  = 5'h05;
  localparam logic [4:0] SEL_EXTI_ANY   = 5'h06;
  localparam logic [4:0] SEL_ADC_IN     = 5'h07;
  localparam logic [4:0] SEL_DIRECT_OUT = 5'h0a;
  localparam logic [4:0] SEL_VREF       = 5'h0e;
  localparam logic [4:0] SEL_RX_CLK     = 5'h0f;
  localparam logic [4:0] SEL_RETRANS    = 5'h11;
  localparam logic [4:0] SEL_RX_DATA    = 5'h14;
  localparam logic [4:0] SEL_RX_STATE   = 5'h15;
  localparam logic [4:0] SEL_FIFO_AFULL = 5'h16;
  localparam logic [4:0] SEL_ANT1       = 5'h17;
  localparam logic [4:0] SEL_ANT2       = 5'h18;
  localparam logic [4:0] SEL_PRE_VALID  = 5'h19;
  localparam logic [4:0] SEL_PRE_INVAL  = 5'h1a;
  localparam logic [4:0] SEL_SYNC_DET   = 5'h1b;
  localparam logic [4:0] SEL_CCA        = 5'h1c;
  localparam logic [4:0] SEL_VDD        = 5'h1d;

endpackage : gfiop_pkg

// *** hdl/gfiop_gpio_port.sv ***
//
// Contract
// - Decode selector; 0 mcu clock, 1D high
// - Selectors 1,2 output wakeup, low battery
// - Selector 0A drives port bit 2
// - Selector 03 reads pin via bit 2
// - Selectors 04-06 falling, rising, any edge interrupt
// - Port bits 6:4 report interrupt status
// - Bit 3 with chip select high: irq on SDO
// - Selectors 0F,14 output rx clock, rx data
// - Selectors 15,16 output rx state, fifo afull
// - Selectors 17,18 output antenna switches
// - Selectors 19-1B output preamble, sync indications
// - Selector 1C outputs clear channel result
// - Selector 11 takes retransmission request input
// - Selectors 07,0E analogue; test codes unused
// - Pull-up only when enabled and digital input
// - Bits 7:6 hold readable drive strength
// - Bits 1,0 direct values for pins 1,0
//
`timescale 1ns/100ps

module gfiop_gpio_port
(
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       srst_i,
  // Register port
  input  wire logic [7:0] reg_addr_i,
  input  wire logic [7:0] reg_wdata_i,
  input  wire logic       reg_wr_i,
  input  wire logic       reg_rd_i,
  output logic      [7:0] reg_rdata_o,
  // Internal status sources
  input  wire logic       mcu_clk_i,
  input  wire logic       wakeup_timer_expired_i,
  input  wire logic       low_batt_i,
  input  wire logic       rx_data_clk_i,
  input  wire logic       rx_data_i,
  input  wire logic       rx_state_i,
  input  wire logic       rx_fifo_afull_i,
  input  wire logic       ant1_switch_i,
  input  wire logic       ant2_switch_i,
  input  wire logic       preamble_valid_i,
  input  wire logic       preamble_invalid_i,
  input  wire logic       sync_word_det_i,
  input  wire logic       cca_i,
  // Third general pin
  input  wire logic       pin2_in_i,
  output logic            pin2_out_o,
  output logic            pin2_oe_n_o,
  output logic            pin2_pullup_en_o,
  output logic      [1:0] pin2_drive_strength_o,
  output logic            pin2_adc_route_o,
  output logic            pin2_vref_out_o,
  output logic            retrans_req_o,
  // First and second pins, function logic kept elsewhere
  input  wire logic       pin0_in_i,
  input  wire logic       pin1_in_i,
  input  wire logic       pin0_is_direct_in_i,
  input  wire logic       pin1_is_direct_in_i,
  input  wire logic       pin0_exti_evt_i,
  input  wire logic       pin1_exti_evt_i,
  output logic            direct_value_pin0_o,
  output logic            direct_value_pin1_o,
  // Serial data-out sharing
  input  wire logic       chip_select_n_i,
  input  wire logic       irq_request_n_i,
  input  wire logic       spi_sdo_i,
  input  wire logic       spi_sdo_oe_n_i,
  output logic            sdo_o,
  output logic            sdo_oe_n_o,
  // Interrupt
  output logic            irq_o
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic is_dig_input(input logic [4:0] sel);
    is_dig_input = (sel == gfiop_pkg::SEL_DIRECT_IN) || (sel == gfiop_pkg::SEL_EXTI_FALL) ||
                   (sel == gfiop_pkg::SEL_EXTI_RISE) || (sel == gfiop_pkg::SEL_EXTI_ANY) ||
                   (sel == gfiop_pkg::SEL_RETRANS);
  endfunction : is_dig_input

  function automatic logic is_analog(input logic [4:0] sel);
    is_analog = (sel == gfiop_pkg::SEL_ADC_IN) || (sel == gfiop_pkg::SEL_VREF);
  endfunction : is_analog

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] cfg_r,       cfg_nxt;
  logic [3:0] port_r,      port_nxt;
  logic [2:0] ext_st_r,    ext_st_nxt;
  logic [2:0] irq_st_r,    irq_st_nxt;
  logic [2:0] irq_mask_r,  irq_mask_nxt;
  logic [7:0] rdata_r,     rdata_nxt;
  logic       pin2_prev_r;
  logic       pin2_out_r,  pin2_out_nxt;
  logic       pin2_oe_n_r, pin2_oe_n_nxt;
  logic       pullup_r,    pullup_nxt;
  logic       sdo_r,       sdo_nxt;
  logic       sdo_oe_n_r,  sdo_oe_n_nxt;
  logic       retrans_r,   retrans_nxt;

  logic [4:0] sel;
  logic [2:0] ext_evt;
  logic       pin2_evt;
  logic       port_read;
  logic [7:0] port_view;

  assign sel = cfg_r[gfiop_pkg::SEL_MSB:gfiop_pkg::SEL_LSB];

  // ----------------------------------------------------------------
  // Edge detection on the third pin
  // ----------------------------------------------------------------
  always_comb
  begin
    unique case (sel)
      gfiop_pkg::SEL_EXTI_FALL: pin2_evt = pin2_prev_r && !pin2_in_i;
      gfiop_pkg::SEL_EXTI_RISE: pin2_evt = !pin2_prev_r && pin2_in_i;
      gfiop_pkg::SEL_EXTI_ANY:  pin2_evt = pin2_prev_r != pin2_in_i;
      default:                  pin2_evt = 1'b0;
    endcase
  end

  assign ext_evt   = {pin2_evt, pin1_exti_evt_i, pin0_exti_evt_i};
  assign port_read = reg_rd_i && (reg_addr_i == gfiop_pkg::ADDR_IO_PORT_CFG);

  // Direct inputs read the pin, otherwise the written value reads back.
  always_comb
  begin
    port_view = {1'b0, ext_st_r, port_r};
    if (sel == gfiop_pkg::SEL_DIRECT_IN)
      port_view[gfiop_pkg::PORT_DIRECT_VALUE_PIN2] = pin2_in_i;
    if (pin1_is_direct_in_i)
      port_view[gfiop_pkg::PORT_DIRECT_VALUE_PIN1] = pin1_in_i;
    if (pin0_is_direct_in_i)
      port_view[gfiop_pkg::PORT_DIRECT_VALUE_PIN0] = pin0_in_i;
  end

  // ----------------------------------------------------------------
  // Registers and interrupt status
  // ----------------------------------------------------------------
  always_comb
  begin
    cfg_nxt      = cfg_r;
    port_nxt     = port_r;
    irq_mask_nxt = irq_mask_r;
    irq_st_nxt   = irq_st_r;
    ext_st_nxt   = ext_st_r;
    rdata_nxt    = 8'h00;
    if (reg_wr_i)
    begin
      unique case (reg_addr_i)
        gfiop_pkg::ADDR_PIN2_FUNC_CFG: cfg_nxt      = reg_wdata_i;
        gfiop_pkg::ADDR_IO_PORT_CFG:   port_nxt     = reg_wdata_i[3:0];
        gfiop_pkg::ADDR_IRQ_MASK:      irq_mask_nxt = reg_wdata_i[2:0];
        gfiop_pkg::ADDR_IRQ_STATUS:    irq_st_nxt   = irq_st_r & ~reg_wdata_i[2:0];
        default:                       cfg_nxt      = cfg_r;
      endcase
    end
    if (reg_rd_i)
    begin
      unique case (reg_addr_i)
        gfiop_pkg::ADDR_PIN2_FUNC_CFG: rdata_nxt = cfg_r;
        gfiop_pkg::ADDR_IO_PORT_CFG:   rdata_nxt = port_view;
        gfiop_pkg::ADDR_IRQ_MASK:      rdata_nxt = {5'h00, irq_mask_r};
        gfiop_pkg::ADDR_IRQ_STATUS:    rdata_nxt = {5'h00, irq_st_r};
        default:                       rdata_nxt = 8'h00;
      endcase
    end
    // A port read clears the port status bits 6:4, but an edge in the same cycle still lands.
    if (port_read)
      ext_st_nxt = 3'h0;
    ext_st_nxt = ext_st_nxt | ext_evt;
    irq_st_nxt = irq_st_nxt | ext_evt;
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  always_comb
  begin
    pin2_oe_n_nxt = is_dig_input(sel) || is_analog(sel);
    pullup_nxt    = cfg_r[gfiop_pkg::PULLUP_BIT] && is_dig_input(sel);
    retrans_nxt   = (sel == gfiop_pkg::SEL_RETRANS) && pin2_in_i;
    unique case (sel)
      gfiop_pkg::SEL_MCU_CLK:    pin2_out_nxt = mcu_clk_i;
      gfiop_pkg::SEL_WAKEUP:     pin2_out_nxt = wakeup_timer_expired_i;
      gfiop_pkg::SEL_LOW_BATT:   pin2_out_nxt = low_batt_i;
      gfiop_pkg::SEL_DIRECT_OUT: pin2_out_nxt = port_r[gfiop_pkg::PORT_DIRECT_VALUE_PIN2];
      gfiop_pkg::SEL_RX_CLK:     pin2_out_nxt = rx_data_clk_i;
      gfiop_pkg::SEL_RX_DATA:    pin2_out_nxt = rx_data_i;
      gfiop_pkg::SEL_RX_STATE:   pin2_out_nxt = rx_state_i;
      gfiop_pkg::SEL_FIFO_AFULL: pin2_out_nxt = rx_fifo_afull_i;
      gfiop_pkg::SEL_ANT1:       pin2_out_nxt = ant1_switch_i;
      gfiop_pkg::SEL_ANT2:       pin2_out_nxt = ant2_switch_i;
      gfiop_pkg::SEL_PRE_VALID:  pin2_out_nxt = preamble_valid_i;
      gfiop_pkg::SEL_PRE_INVAL:  pin2_out_nxt = preamble_invalid_i;
      gfiop_pkg::SEL_SYNC_DET:   pin2_out_nxt = sync_word_det_i;
      gfiop_pkg::SEL_CCA:        pin2_out_nxt = cca_i;
      gfiop_pkg::SEL_VDD:        pin2_out_nxt = 1'b1;
      default:                   pin2_out_nxt = 1'b0;
    endcase
    // Outside a transaction the SDO pin may carry the interrupt request.
    if (!chip_select_n_i)
    begin
      sdo_nxt      = spi_sdo_i;
      sdo_oe_n_nxt = spi_sdo_oe_n_i;
    end
    else
    begin
      sdo_nxt      = irq_request_n_i;
      sdo_oe_n_nxt = !port_r[gfiop_pkg::PORT_IRQ_SDO];
    end
  end

  // ----------------------------------------------------------------
  // Flip-flops
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      cfg_r       <= gfiop_pkg::RST_PIN2_FUNC_CFG;
      port_r      <= gfiop_pkg::RST_IO_PORT_WR;
      ext_st_r    <= 3'h0;
      irq_st_r    <= 3'h0;
      irq_mask_r  <= gfiop_pkg::RST_IRQ_MASK;
      rdata_r     <= 8'h00;
      pin2_prev_r <= 1'b0;
      pin2_out_r  <= 1'b0;
      pin2_oe_n_r <= 1'b1;
      pullup_r    <= 1'b0;
      sdo_r       <= 1'b1;
      sdo_oe_n_r  <= 1'b1;
      retrans_r   <= 1'b0;
    end
    else
    begin
      cfg_r       <= cfg_nxt;
      port_r      <= port_nxt;
      ext_st_r    <= ext_st_nxt;
      irq_st_r    <= irq_st_nxt;
      irq_mask_r  <= irq_mask_nxt;
      rdata_r     <= rdata_nxt;
      pin2_prev_r <= pin2_in_i;
      pin2_out_r  <= pin2_out_nxt;
      pin2_oe_n_r <= pin2_oe_n_nxt;
      pullup_r    <= pullup_nxt;
      sdo_r       <= sdo_nxt;
      sdo_oe_n_r  <= sdo_oe_n_nxt;
      retrans_r   <= retrans_nxt;
    end
  end

  assign reg_rdata_o           = rdata_r;
  assign pin2_out_o            = pin2_out_r;
  assign pin2_oe_n_o           = pin2_oe_n_r;
  assign pin2_pullup_en_o      = pullup_r;
  assign pin2_drive_strength_o = cfg_r[gfiop_pkg::DRV_MSB:gfiop_pkg::DRV_LSB];
  assign pin2_adc_route_o      = sel == gfiop_pkg::SEL_ADC_IN;
  assign pin2_vref_out_o       = sel == gfiop_pkg::SEL_VREF;
  assign retrans_req_o         = retrans_r;
  assign direct_value_pin0_o   = port_r[gfiop_pkg::PORT_DIRECT_VALUE_PIN0];
  assign direct_value_pin1_o   = port_r[gfiop_pkg::PORT_DIRECT_VALUE_PIN1];
  assign sdo_o                 = sdo_r;
  assign sdo_oe_n_o            = sdo_oe_n_r;
  assign irq_o                 = |(irq_st_r & irq_mask_r);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_vdd_high;
    @(posedge sys_clk_i) disable iff (srst_i)
    sel == gfiop_pkg::SEL_VDD |=> pin2_out_o && !pin2_oe_n_o;
  endproperty
  a_vdd_high: assert property (p_vdd_high) else $error("Pin not high for VDD code");

  property p_unlisted_low;
    @(posedge sys_clk_i) disable iff (srst_i)
    sel > gfiop_pkg::SEL_VDD |=> !pin2_out_o;
  endproperty
  a_unlisted_low: assert property (p_unlisted_low) else $error("Unlisted code not low");

  property p_direct_out;
    @(posedge sys_clk_i) disable iff (srst_i)
    sel == gfiop_pkg::SEL_DIRECT_OUT |=> pin2_out_o == $past(port_r[2]);
  endproperty
  a_direct_out: assert property (p_direct_out) else $error("Direct output mismatch");

  property p_direct_in;
    @(posedge sys_clk_i) disable iff (srst_i)
    port_read && sel == gfiop_pkg::SEL_DIRECT_IN |=> reg_rdata_o[2] == $past(pin2_in_i);
  endproperty
  a_direct_in: assert property (p_direct_in) else $error("Direct input readback wrong");

  property p_rise_sets;
    @(posedge sys_clk_i) disable iff (srst_i)
    sel == gfiop_pkg::SEL_EXTI_RISE && $rose(pin2_in_i) |=> ext_st_r[2] && irq_st_r[2];
  endproperty
  a_rise_sets: assert property (p_rise_sets) else $error("Rising edge not caught");

  property p_read_clears;
    @(posedge sys_clk_i) disable iff (srst_i)
    port_read && ext_evt == 3'h0 |=> ext_st_r == 3'h0;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("Status kept after read");

  property p_sdo_irq;
    @(posedge sys_clk_i) disable iff (srst_i)
    chip_select_n_i && port_r[3] |=> sdo_o == $past(irq_request_n_i) && !sdo_oe_n_o;
  endproperty
  a_sdo_irq: assert property (p_sdo_irq) else $error("Interrupt not on SDO");

  property p_pullup;
    @(posedge sys_clk_i) disable iff (srst_i)
    cfg_r[5] && sel == gfiop_pkg::SEL_DIRECT_IN ##1 cfg_r[5] |-> pin2_pullup_en_o;
  endproperty
  a_pullup: assert property (p_pullup) else $error("Pull-up missing on input");

  property p_rx_data;
    @(posedge sys_clk_i) disable iff (srst_i)
    sel == gfiop_pkg::SEL_RX_DATA |=> pin2_out_o == $past(rx_data_i);
  endproperty
  a_rx_data: assert property (p_rx_data) else $error("RX data not routed");

endmodule : gfiop_gpio_port

// *** verification/gfiop_pin_model.sv ***
`timescale 1ns/100ps

// ----------------------------------------------------------------
// Board-side model of the third general pin
// ----------------------------------------------------------------
module gfiop_pin_model
(
  // Clock
  input  wire logic clk_i,
  // Device side of the pin
  input  wire logic drive_i,
  input  wire logic drive_oe_n_i,
  input  wire logic pullup_en_i,
  // External circuitry
  input  wire logic ext_en_i,
  input  wire logic ext_val_i,
  // Resolved pin level
  output logic      pin_o
);
  // An undriven pin toggles every cycle so that a stale level is never mistaken for a real one.
  logic float_r = 1'b0;

  always_ff @(posedge clk_i)
  begin
    float_r <= ~float_r;
  end

  always_comb
  begin
    if (!drive_oe_n_i)
      pin_o = drive_i;
    else if (ext_en_i)
      pin_o = ext_val_i;
    else if (pullup_en_i)
      pin_o = 1'b1;
    else
      pin_o = float_r;
  end
endmodule : gfiop_pin_model

// *** verification/gpio_function_and_io_port_tb.sv ***
`timescale 1ns/100ps

module gpio_function_and_io_port_tb;
  logic        sys_clk_i, srst_i, reg_wr_i, reg_rd_i;
  logic  [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic [12:0] src;
  logic        pin2_in_i, pin2_out_o, pin2_oe_n_o, pin2_pullup_en_o, pin2_adc_route_o;
  logic        pin2_vref_out_o, retrans_req_o, ext_en, ext_val;
  logic  [1:0] pin2_drive_strength_o;
  logic        pin0_in_i, pin1_in_i, pin0_dir_i, pin1_dir_i, pin0_evt_i, pin1_evt_i;
  logic        dv0_o, dv1_o, cs_n_i, irq_req_n_i, spi_sdo_i, spi_oe_n_i, sdo_o, sdo_oe_n_o, irq_o;
  int          errors, total_checks;

  gfiop_gpio_port dut (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .mcu_clk_i(src[0]), .wakeup_timer_expired_i(src[1]),
    .low_batt_i(src[2]), .rx_data_clk_i(src[3]), .rx_data_i(src[4]), .rx_state_i(src[5]),
    .rx_fifo_afull_i(src[6]), .ant1_switch_i(src[7]), .ant2_switch_i(src[8]),
    .preamble_valid_i(src[9]), .preamble_invalid_i(src[10]), .sync_word_det_i(src[11]),
    .cca_i(src[12]), .pin2_in_i(pin2_in_i), .pin2_out_o(pin2_out_o), .pin2_oe_n_o(pin2_oe_n_o),
    .pin2_pullup_en_o(pin2_pullup_en_o), .pin2_drive_strength_o(pin2_drive_strength_o),
    .pin2_adc_route_o(pin2_adc_route_o), .pin2_vref_out_o(pin2_vref_out_o),
    .retrans_req_o(retrans_req_o), .pin0_in_i(pin0_in_i), .pin1_in_i(pin1_in_i),
    .pin0_is_direct_in_i(pin0_dir_i), .pin1_is_direct_in_i(pin1_dir_i),
    .pin0_exti_evt_i(pin0_evt_i), .pin1_exti_evt_i(pin1_evt_i), .direct_value_pin0_o(dv0_o),
    .direct_value_pin1_o(dv1_o), .chip_select_n_i(cs_n_i), .irq_request_n_i(irq_req_n_i),
    .spi_sdo_i(spi_sdo_i), .spi_sdo_oe_n_i(spi_oe_n_i), .sdo_o(sdo_o),
    .sdo_oe_n_o(sdo_oe_n_o), .irq_o(irq_o));

  gfiop_pin_model u_pin (.clk_i(sys_clk_i), .drive_i(pin2_out_o), .drive_oe_n_i(pin2_oe_n_o),
    .pullup_en_i(pin2_pullup_en_o), .ext_en_i(ext_en), .ext_val_i(ext_val), .pin_o(pin2_in_i));

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b1; reg_addr_i <= a; reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b1; reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_rd_i <= 1'b0;
    #1 chk(reg_rdata_o, exp);
  endtask : rdchk

  // Registered pin paths need one edge for the source and one for the output.
  task automatic settle();
    repeat (2) @(posedge sys_clk_i);
    #1;
  endtask : settle

  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rdchk(8'h0d, 8'h00); rdchk(8'h0e, 8'h00); rdchk(8'h21, 8'h00);
    chk(pin2_oe_n_o, 1'b0); chk(irq_o, 1'b0); chk(sdo_o, 1'b1);
    wr(8'h0d, 8'hc7); settle();
    rdchk(8'h0d, 8'hc7);
    chk(pin2_drive_strength_o, 2'h3);
    chk({pin2_adc_route_o, pin2_oe_n_o}, 2'b11);
    wr(8'h0d, 8'h4e); settle();
    chk({pin2_vref_out_o, pin2_drive_strength_o}, 3'b101);
    wr(8'h33, 8'hff); rdchk(8'h33, 8'h00);
    wr(8'h0e, 8'hff); rdchk(8'h0e, 8'h0f);
    chk({dv1_o, dv0_o}, 2'b11);
    wr(8'h0e, 8'h00);
  endtask : t_regs

  task automatic t_outputs();
    logic [4:0] codes [13];
    logic [4:0] resv [8];
    codes = '{gfiop_pkg::SEL_MCU_CLK, gfiop_pkg::SEL_WAKEUP, gfiop_pkg::SEL_LOW_BATT,
      gfiop_pkg::SEL_RX_CLK, gfiop_pkg::SEL_RX_DATA, gfiop_pkg::SEL_RX_STATE,
      gfiop_pkg::SEL_FIFO_AFULL, gfiop_pkg::SEL_ANT1, gfiop_pkg::SEL_ANT2,
      gfiop_pkg::SEL_PRE_VALID, gfiop_pkg::SEL_PRE_INVAL, gfiop_pkg::SEL_SYNC_DET,
      gfiop_pkg::SEL_CCA};
    resv = '{5'h08, 5'h09, 5'h0b, 5'h0c, 5'h0d, 5'h10, 5'h12, 5'h13};
    for (int i = 0; i < 13; i++)
    begin
      wr(8'h0d, {3'b000, codes[i]});
      src <= 13'h0001 << i; settle();
      chk({pin2_out_o, pin2_oe_n_o}, 2'b10);
      src <= ~(13'h0001 << i); settle();
      chk({pin2_out_o, pin2_oe_n_o}, 2'b00);
    end
    src <= 13'h0000;
    wr(8'h0d, {3'b000, gfiop_pkg::SEL_VDD}); settle();
    chk(pin2_out_o, 1'b1);
    src <= 13'h1fff;
    for (int i = 0; i < 8; i++)
    begin
      wr(8'h0d, {3'b000, resv[i]}); settle();
      chk(pin2_out_o, 1'b0);
    end
    wr(8'h0d, 8'h3f); settle();
    chk(pin2_out_o, 1'b0);
    wr(8'h0d, 8'h2a); wr(8'h0e, 8'h04); settle();
    chk({pin2_out_o, pin2_oe_n_o, pin2_pullup_en_o}, 3'b100);
    wr(8'h0e, 8'h00); settle();
    chk(pin2_out_o, 1'b0);
  endtask : t_outputs

  task automatic t_inputs();
    ext_en <= 1'b0; pin1_dir_i <= 1'b1; pin1_in_i <= 1'b1;
    wr(8'h0d, 8'h23); settle();
    chk({pin2_pullup_en_o, pin2_oe_n_o}, 2'b11);
    rdchk(8'h0e, 8'h06);
    ext_en <= 1'b1; ext_val <= 1'b0; settle();
    rdchk(8'h0e, 8'h02);
    wr(8'h0d, 8'h11); ext_val <= 1'b1; settle();
    chk(retrans_req_o, 1'b1);
    ext_val <= 1'b0; settle();
    chk(retrans_req_o, 1'b0);
    pin1_dir_i <= 1'b0;
  endtask : t_inputs

  task automatic t_exti();
    logic [4:0] m;
    wr(8'h21, 8'h07);
    for (int i = 4; i < 7; i++)
    begin
      m = i[4:0];
      ext_val <= 1'b0; wr(8'h0d, {3'b000, m}); settle();
      wr(8'h20, 8'h07); rdchk(8'h0e, 8'h00);
      ext_val <= 1'b1; settle();
      chk(irq_o, m != gfiop_pkg::SEL_EXTI_FALL);
      wr(8'h21, 8'h00); #1 chk(irq_o, 1'b0);
      wr(8'h21, 8'h07); wr(8'h20, 8'h04); #1 chk(irq_o, 1'b0);
      rdchk(8'h0e, (m != gfiop_pkg::SEL_EXTI_FALL) ? 8'h40 : 8'h00);
      rdchk(8'h0e, 8'h00);
      ext_val <= 1'b0; settle();
      rdchk(8'h20, (m != gfiop_pkg::SEL_EXTI_RISE) ? 8'h04 : 8'h00);
      rdchk(8'h0e, (m != gfiop_pkg::SEL_EXTI_RISE) ? 8'h40 : 8'h00);
    end
    wr(8'h20, 8'h07);
    @(posedge sys_clk_i) pin0_evt_i <= 1'b1;
    @(posedge sys_clk_i) pin0_evt_i <= 1'b0;
    #1 rdchk(8'h0e, 8'h10);
    rdchk(8'h20, 8'h01);
    wr(8'h20, 8'h01); rdchk(8'h20, 8'h00);
  endtask : t_exti

  task automatic t_sdo();
    cs_n_i <= 1'b1; irq_req_n_i <= 1'b0;
    wr(8'h0e, 8'h08); settle();
    chk({sdo_o, sdo_oe_n_o}, 2'b00);
    irq_req_n_i <= 1'b1; settle();
    chk({sdo_o, sdo_oe_n_o}, 2'b10);
    cs_n_i <= 1'b0; spi_sdo_i <= 1'b0; spi_oe_n_i <= 1'b0; settle();
    chk({sdo_o, sdo_oe_n_o}, 2'b00);
    cs_n_i <= 1'b1; wr(8'h0e, 8'h00); settle();
    chk(sdo_oe_n_o, 1'b1);
  endtask : t_sdo

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk_i);
    errors++;
    stop_test();
  end

  initial
  begin
    errors = 0; total_checks = 0; srst_i = 1'b1; reg_wr_i = 1'b0; reg_rd_i = 1'b0;
    reg_addr_i = 8'h00; reg_wdata_i = 8'h00; src = 13'h0000; ext_en = 1'b0; ext_val = 1'b0;
    pin0_in_i = 1'b0; pin1_in_i = 1'b0; pin0_dir_i = 1'b0; pin1_dir_i = 1'b0;
    pin0_evt_i = 1'b0; pin1_evt_i = 1'b0; cs_n_i = 1'b1; irq_req_n_i = 1'b1;
    spi_sdo_i = 1'b1; spi_oe_n_i = 1'b1;
    repeat (6) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    t_regs();
    t_outputs();
    t_inputs();
    t_exti();
    t_sdo();
    stop_test();
  end
endmodule : gpio_function_and_io_port_tb
